/* File: src/correctable_error_status.sv */
`timescale 1ns/1ps
module correctable_error_status
  import ces_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,

  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,

  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,

  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,

  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,

  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,

  // error events from the link layers
  input wire err_events_t err_events,

  // uncorrectable side state
  input wire first_error_t first_error,

  // reporting
  output logic header_log_store,
  output logic error_report,
  output logic irq
);

  // ==========================================================
  // state

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] irq_status;
    logic [31:0] irq_enable;
    logic header_log_store;
    logic error_report;
    logic irq;
  } ces_state_t;

  localparam ces_state_t CES_RESET = '{
    status: STATUS_RESET,
    mask: MASK_RESET,
    irq_status: STATUS_RESET,
    irq_enable: IRQ_ENABLE_RESET,
    default: '0
  };

  ces_state_t s;
  ces_state_t next_s;

  reg_write_t wr;
  logic [31:0] rd_data;
  logic [31:0] ev;
  logic fep_valid;
  logic log_overflow;
  logic [31:0] status_clr;
  logic [31:0] irq_clr;

  // ==========================================================
  // bus front end

  axil_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .rd_data(rd_data),
    .wr(wr)
  );

  // ==========================================================
  // event decode

  always_comb
  begin
    // a pointer to a bit that software already cleared no longer blocks the log
    fep_valid = first_error.uncorrectable_error_status[first_error.first_error_pointer];
    log_overflow = err_events.header_log_request && fep_valid;
    ev = '0;
    ev[RCV_BIT] = err_events.receiver_error;
    ev[BAD_PKT_BIT] = err_events.bad_packet;
    ev[BAD_LINK_BIT] = err_events.bad_link_packet;
    ev[ROLLOVER_BIT] = err_events.replay_rollover;
    ev[REPLAY_TO_BIT] = err_events.replay_timeout;
    ev[ADVISORY_BIT] = err_events.advisory_nonfatal;
    ev[INTERNAL_BIT] = err_events.correctable_internal;
    ev[HLO_BIT] = log_overflow;
  end

  // ==========================================================
  // register update

  always_comb
  begin
    next_s = s;
    // clears follow the byte lanes, so a narrow write leaves the other lanes alone
    status_clr = '0;
    irq_clr = '0;
    if (wr.en && (wr.addr == STATUS_ADDR))
      status_clr = wr.data & lane_mask(wr.strb);
    if (wr.en && (wr.addr == IRQ_CLEAR_ADDR))
      irq_clr = wr.data & lane_mask(wr.strb);
    if (wr.en && (wr.addr == MASK_ADDR))
      next_s.mask = merge_write(s.mask, wr.data, wr.strb);
    if (wr.en && (wr.addr == IRQ_ENABLE_ADDR))
      next_s.irq_enable = merge_write(s.irq_enable, wr.data, wr.strb);
    // an event in the clearing cycle wins, so no error is lost
    next_s.status = ((s.status & ~status_clr) | ev) & DEFINED_BITS;
    next_s.irq_status = ((s.irq_status & ~irq_clr) | ev) & DEFINED_BITS;
    // the mask only gates the report, the status above ignores it
    next_s.error_report = |(ev & ~s.mask);
    next_s.header_log_store = err_events.header_log_request && !fep_valid;
    next_s.irq = |(next_s.irq_status & next_s.irq_enable);
  end

  // only the fundamental reset clears the sticky bits; no other reset reaches them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= CES_RESET;
    else
      s <= next_s;
  end

  // ==========================================================
  // read mux
  // follows araddr directly; the port captures it only on the accepting edge

  always_comb
  begin
    case (araddr)
      STATUS_ADDR: rd_data = s.status;
      MASK_ADDR: rd_data = s.mask;
      IRQ_STATUS_ADDR: rd_data = s.irq_status;
      IRQ_ENABLE_ADDR: rd_data = s.irq_enable;
      default: rd_data = '0;
    endcase
  end

  assign header_log_store = s.header_log_store;
  assign error_report = s.error_report;
  assign irq = s.irq;

  // ==========================================================
  // assertions

  default clocking cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  a_rcv_sets: assert property (
    err_events.receiver_error |=> s.status[RCV_BIT]
  ) else $error("receiver error did not set its status bit");

  a_bad_pkt_sets: assert property (
    err_events.bad_packet |=> s.status[BAD_PKT_BIT] && s.irq_status[BAD_PKT_BIT]
  ) else $error("bad packet did not set its status bit");

  a_bad_link_sets: assert property (
    err_events.bad_link_packet |=> s.status[BAD_LINK_BIT]
  ) else $error("bad link packet did not set its status bit");

  a_rollover_sets: assert property (
    err_events.replay_rollover |=> s.status[ROLLOVER_BIT]
  ) else $error("replay rollover did not set its status bit");

  a_replay_to_sets: assert property (
    err_events.replay_timeout |=> s.status[REPLAY_TO_BIT]
  ) else $error("replay timeout did not set its status bit");

  a_advisory_sets: assert property (
    err_events.advisory_nonfatal |=> s.status[ADVISORY_BIT]
  ) else $error("advisory error did not set its status bit");

  a_internal_sets: assert property (
    err_events.correctable_internal |=> s.status[INTERNAL_BIT]
  ) else $error("internal error did not set its status bit");

  a_overflow_sets: assert property (
    err_events.header_log_request && fep_valid |=> s.status[HLO_BIT] && !header_log_store
  ) else $error("blocked header log did not flag overflow");

  a_log_accepts: assert property (
    err_events.header_log_request && !fep_valid |=> header_log_store
  ) else $error("free header log did not store the header");

  a_no_false_hlo: assert property (
    !s.status[HLO_BIT] && !log_overflow |=> !s.status[HLO_BIT]
  ) else $error("overflow flag set without a valid pointer");

  a_w1c_clears: assert property (
    wr.en && (wr.addr == STATUS_ADDR) && wr.strb[0] && wr.data[RCV_BIT] && !ev[RCV_BIT]
    |=> !s.status[RCV_BIT]
  ) else $error("writing one did not clear the status bit");

  a_w0_keeps: assert property (
    s.status[INTERNAL_BIT] && !(wr.en && (wr.addr == STATUS_ADDR) && wr.strb[1] && wr.data[INTERNAL_BIT])
    |=> s.status[INTERNAL_BIT]
  ) else $error("status bit lost without a one written");

  a_set_wins: assert property (
    wr.en && (wr.addr == STATUS_ADDR) && wr.strb[0] && wr.data[RCV_BIT] && ev[RCV_BIT]
    |=> s.status[RCV_BIT]
  ) else $error("event lost in the clearing cycle");

  a_reserved_zero: assert property (
    ((s.status | s.mask | s.irq_status | s.irq_enable) & ~DEFINED_BITS) == '0
  ) else $error("reserved bits are not zero");

  a_mask_no_effect: assert property (
    (ev & s.mask) != '0 |=> (s.status & $past(ev & s.mask)) == $past(ev & s.mask)
  ) else $error("masked event did not set its status bit");

  a_report_gated: assert property (
    (ev & ~s.mask) != '0 |=> error_report ##1 !error_report || $past((ev & ~s.mask) != '0)
  ) else $error("unmasked event was not reported");

  a_irq_level: assert property (
    (s.irq_status & s.irq_enable) != '0 |-> irq
  ) else $error("interrupt low with an enabled status bit");

  // ==========================================================
  // bus, register write, reporting and interrupt assertions
  // the bus ones watch the port from outside, so any change inside it is still held to the handshake

  a_bresp_holds: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)
  ) else $error("write response dropped before it was taken");

  a_rdata_holds: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)
  ) else $error("read data changed before it was taken");

  a_read_blocks: assert property (
    rvalid |-> !arready
  ) else $error("read address accepted with a read still pending");

  a_write_answers: assert property (
    wr.en |=> bvalid
  ) else $error("applied write got no response");

  a_read_unmapped: assert property (
    arvalid && arready && !reg_mapped(araddr)
    |=> rvalid && (rresp == RESP_SLVERR) && (rdata == '0)
  ) else $error("unmapped read did not return an error and zero");

  a_read_reserved: assert property (
    rvalid |-> (rdata & ~DEFINED_BITS) == '0
  ) else $error("read data shows a reserved bit");

  a_mask_write: assert property (
    wr.en && (wr.addr == MASK_ADDR) && (wr.strb == 4'hf)
    |=> s.mask == ($past(wr.data) & DEFINED_BITS)
  ) else $error("mask write did not land on the defined bits");

  a_enable_write: assert property (
    wr.en && (wr.addr == IRQ_ENABLE_ADDR) && (wr.strb == 4'hf)
    |=> s.irq_enable == ($past(wr.data) & DEFINED_BITS)
  ) else $error("enable write did not land on the defined bits");

  a_report_source: assert property (
    error_report |-> $past((ev & ~s.mask) != '0)
  ) else $error("error report without an unmasked event");

  a_report_masked: assert property (
    (ev & ~s.mask) == '0 |=> !error_report
  ) else $error("masked or absent event was reported");

  a_store_source: assert property (
    header_log_store |-> $past(err_events.header_log_request && !fep_valid)
  ) else $error("header stored without a free log");

  a_irq_clears: assert property (
    wr.en && (wr.addr == IRQ_CLEAR_ADDR) && wr.strb[0] && wr.data[BAD_PKT_BIT] && !ev[BAD_PKT_BIT]
    |=> !s.irq_status[BAD_PKT_BIT]
  ) else $error("interrupt clear did not clear the pending bit");

  a_irq_status_ro: assert property (
    wr.en && (wr.addr == IRQ_STATUS_ADDR) && (ev == '0)
    |=> s.irq_status == $past(s.irq_status)
  ) else $error("write changed the read-only pending register");

  a_status_apart: assert property (
    wr.en && (wr.addr == STATUS_ADDR)
    |=> (s.irq_status & $past(s.irq_status)) == $past(s.irq_status)
  ) else $error("status clear reached the pending register");

  a_event_to_irq: assert property (
    err_events.bad_packet && s.irq_enable[BAD_PKT_BIT] && !wr.en
    |=> irq
  ) else $error("enabled event did not raise the interrupt");

  c_overflow: cover property (
    err_events.header_log_request && fep_valid ##1 s.status[HLO_BIT]
  );

  c_clear_status: cover property (
    s.status[RCV_BIT] ##1 wr.en && (wr.addr == STATUS_ADDR) ##1 !s.status[RCV_BIT]
  );

  c_masked_event: cover property (
    (ev & s.mask) != '0 ##1 !error_report
  );

  c_irq_raise: cover property (
    !irq ##1 irq
  );

  c_log_stored: cover property (
    err_events.header_log_request && !fep_valid ##1 header_log_store
  );

endmodule : correctable_error_status

/* File: src/ces_pkg.sv */
package ces_pkg;


// ==========================================================
// register map
localparam int ADDR_W = 12;
localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h110;
localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h114;
localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 12'h120;
localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 12'h124;
localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = 12'h128;

// ==========================================================
// field positions and reset values
localparam int RCV_BIT = 0;
localparam int BAD_PKT_BIT = 6;
localparam int BAD_LINK_BIT = 7;
localparam int ROLLOVER_BIT = 8;
localparam int REPLAY_TO_BIT = 12;
localparam int ADVISORY_BIT = 13;
localparam int INTERNAL_BIT = 14;
localparam int HLO_BIT = 15;
localparam logic [31:0] DEFINED_BITS = 32'h0000_f1c1;
localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
localparam logic [31:0] MASK_RESET = 32'h0000_e000;
localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_SLVERR = 2'h2;

// ==========================================================
// carriers
typedef struct packed {
  logic receiver_error;
  logic bad_packet;
  logic bad_link_packet;
  logic replay_rollover;
  logic replay_timeout;
  logic advisory_nonfatal;
  logic correctable_internal;
  logic header_log_request;
} err_events_t;

typedef struct packed {
  logic [31:0] uncorrectable_error_status;
  logic [4:0] first_error_pointer;
} first_error_t;

typedef struct packed {
  logic en;
  logic [ADDR_W-1:0] addr;
  logic [31:0] data;
  logic [3:0] strb;
} reg_write_t;

// ==========================================================
// helpers
function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
  reg_mapped = (addr == STATUS_ADDR) || (addr == MASK_ADDR) || (addr == IRQ_STATUS_ADDR) ||
               (addr == IRQ_ENABLE_ADDR) || (addr == IRQ_CLEAR_ADDR);
endfunction : reg_mapped

function automatic logic [31:0] lane_mask(input logic [3:0] strb);
  lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
endfunction : lane_mask

function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
  merge_write = ((old & ~lane_mask(strb)) | (data & lane_mask(strb))) & DEFINED_BITS;
endfunction : merge_write

endpackage : ces_pkg

/* File: src/axil_port.sv */
`timescale 1ns/1ps
module axil_port
  import ces_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register side
  input wire logic [31:0] rd_data,
  output reg_write_t wr
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } port_state_t;

  localparam port_state_t PORT_RESET = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

  port_state_t s;
  port_state_t next_s;

  // ==========================================================
  // handshakes
  always_comb
  begin
    next_s = s;
    wr = '0;
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (awvalid && s.awready)
    begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_full = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    // a write is applied only once its previous response has been taken
    if (s.aw_full && s.w_full && !s.bvalid)
    begin
      wr.en = 1'b1;
      wr.addr = s.awaddr;
      wr.data = s.wdata;
      wr.strb = s.wstrb;
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = reg_mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready = !next_s.w_full;
    if (arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_data;
      next_s.rresp = reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= PORT_RESET;
    else
      s <= next_s;
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;

endmodule : axil_port

/* File: tb/correctable_error_status_tb.sv */
`timescale 1ns/1ps
module correctable_error_status_tb
  import ces_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, exp, d;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, resp;
  err_events_t err_events = '0;
  first_error_t first_error = '0;
  logic header_log_store, error_report, irq, rep, store;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  int bit_pos[7] = '{RCV_BIT, BAD_PKT_BIT, BAD_LINK_BIT, ROLLOVER_BIT, REPLAY_TO_BIT, ADVISORY_BIT, INTERNAL_BIT};

  correctable_error_status dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .err_events(err_events),
    .first_error(first_error), .header_log_store(header_log_store), .error_report(error_report), .irq(irq));

  always #2.5 aclk = ~aclk;

  // ==========================================================
  // checking and closing
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    comparisons++;
    if (seen !== expected)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  // a hung handshake must not stall the run forever
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  // ==========================================================
  // axi4-lite master
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat, input logic [3:0] s);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= dat;
    wstrb <= s;
    bready <= 1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1;
        awvalid <= 0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge aclk);
    resp = bresp;
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 0;
  endtask : rd

  task automatic check_reg(input logic [ADDR_W-1:0] a, input logic [31:0] expected);
    rd(a);
    check(d, expected);
    check(resp, RESP_OKAY);
  endtask : check_reg

  // one event cycle; pulses are sampled in the cycle after the event edge
  task automatic fire(input err_events_t ev);
    @(posedge aclk);
    err_events <= ev;
    @(posedge aclk);
    err_events <= '0;
    #1;
    rep = error_report;
    store = header_log_store;
  endtask : fire

  // ==========================================================
  // tests
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;

    check_reg(STATUS_ADDR, STATUS_RESET);
    check_reg(MASK_ADDR, MASK_RESET);
    check_reg(IRQ_ENABLE_ADDR, IRQ_ENABLE_RESET);
    check_reg(IRQ_STATUS_ADDR, 32'h0000_0000);
    rd(12'h200);
    check(d, 32'h0000_0000);
    check(resp, RESP_SLVERR);
    $display("test reset_values done");

    // each event sets only its own bit; default mask hides bits 13 and 14 from reporting
    exp = '0;
    for (int k = 0; k < 7; k++)
    begin
      fire(err_events_t'(8'h80 >> k));
      check(rep, !MASK_RESET[bit_pos[k]]);
      exp[bit_pos[k]] = 1'b1;
      check_reg(STATUS_ADDR, exp);
    end
    $display("test event_bits done");

    wr(STATUS_ADDR, 32'h0000_0000, 4'hf);
    check(resp, RESP_OKAY);
    check_reg(STATUS_ADDR, exp);
    // only byte lane 0 enabled: bits 0, 6 and 7 go, the rest stays
    wr(STATUS_ADDR, 32'hffff_ffff, 4'h1);
    exp = exp & ~32'h0000_00c1;
    check_reg(STATUS_ADDR, exp);
    wr(STATUS_ADDR, 32'hffff_ffff, 4'hf);
    check_reg(STATUS_ADDR, 32'h0000_0000);
    wr(MASK_ADDR, 32'hffff_ffff, 4'hf);
    check_reg(MASK_ADDR, DEFINED_BITS);
    $display("test clear_and_reserved done");

    fire(err_events_t'(8'h80));
    check(rep, 1'b0);
    check_reg(STATUS_ADDR, 32'h0000_0001);
    // event held through the clearing write: the set must win
    err_events <= err_events_t'(8'h80);
    wr(STATUS_ADDR, 32'h0000_0001, 4'hf);
    err_events <= '0;
    check_reg(STATUS_ADDR, 32'h0000_0001);
    wr(STATUS_ADDR, 32'h0000_0001, 4'hf);
    $display("test mask_keeps_status done");

    // pointer 4 indexes a set uncorrectable bit, so the log counts as full
    first_error <= {32'h0000_0010, 5'd4};
    fire(err_events_t'(8'h01));
    check(store, 1'b0);
    check_reg(STATUS_ADDR, 32'h0000_8000);
    wr(STATUS_ADDR, 32'h0000_8000, 4'hf);
    first_error <= {32'h0000_0010, 5'd3};
    fire(err_events_t'(8'h01));
    check(store, 1'b1);
    check_reg(STATUS_ADDR, 32'h0000_0000);
    $display("test header_log done");

    wr(IRQ_CLEAR_ADDR, 32'hffff_ffff, 4'hf);
    check_reg(IRQ_STATUS_ADDR, 32'h0000_0000);
    wr(IRQ_ENABLE_ADDR, 32'h0000_0040, 4'hf);
    fire(err_events_t'(8'h10));
    check(irq, 1'b0);
    fire(err_events_t'(8'h40));
    check(irq, 1'b1);
    wr(IRQ_STATUS_ADDR, 32'hffff_ffff, 4'hf);
    check(resp, RESP_OKAY);
    check_reg(IRQ_STATUS_ADDR, 32'h0000_0140);
    wr(IRQ_CLEAR_ADDR, 32'h0000_0040, 4'hf);
    @(posedge aclk);
    #1;
    check(irq, 1'b0);
    wr(12'h300, 32'hffff_ffff, 4'hf);
    check(resp, RESP_SLVERR);
    $display("test interrupt done");

    // sticky bits only go away with the reset itself
    fire(err_events_t'(8'h02));
    check_reg(STATUS_ADDR, 32'h0000_4140);
    @(posedge aclk);
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    check_reg(STATUS_ADDR, STATUS_RESET);
    $display("test second_reset done");
    summarize();
  end
endmodule : correctable_error_status_tb
